// >>> rtl/dsrc_pkg.sv
// Purpose: shared constants and types for the receiver configuration bank
// Assumes: 8-bit register port, 50 MHz core clock
// Notes: offsets are byte addresses on the plain register port
package dsrc_pkg;

    // ========================================
    // register map
    localparam logic [7:0] OFS_CHAN_CONFIG = 8'h10;
    localparam logic [7:0] OFS_LANE_EQ = 8'h11;
    localparam logic [7:0] OFS_CLOCK_BAND = 8'h12;

    // ========================================
    // reset values
    localparam logic [7:0] RST_CHAN_CONFIG = 8'h3e;
    localparam logic [7:0] RST_LANE_EQ = 8'h00;
    localparam logic [7:0] RST_CLOCK_BAND = 8'h00;

    // ========================================
    // field positions in the channel configuration register
    localparam int POS_PIXEL_SPLIT = 7;
    localparam int POS_MODE_LO = 5;
    localparam int POS_LANES_A_LO = 3;
    localparam int POS_LANES_B_LO = 1;
    localparam int POS_STRICT = 0;

    // ========================================
    // equalization field low bits: a data, b data, a clock, b clock
    localparam int POS_EQ_A_DATA_LO = 6;
    localparam int POS_EQ_B_DATA_LO = 4;
    localparam int POS_EQ_A_CLK_LO = 2;
    localparam int POS_EQ_B_CLK_LO = 0;

    // ========================================
    // receiver mode codes
    localparam logic [1:0] MODE_DUAL_RX = 2'h0;
    localparam logic [1:0] MODE_SINGLE_RX = 2'h1;
    localparam logic [1:0] MODE_TWO_RX = 2'h2;

    // ========================================
    // clock band limits, 5 MHz steps
    localparam logic [7:0] BAND_MIN = 8'h08;
    localparam logic [7:0] BAND_MAX = 8'h64;

    // ========================================
    // start-of-transmission leader, first bit in bit 0
    localparam logic [7:0] LEADER_PATTERN = 8'hb8;

    // decoded settings handed to the analog front end and datapath
    typedef struct packed {
        logic left_right;
        logic dual_rx;
        logic single_rx;
        logic two_rx;
        logic [3:0] lanes_a;
        logic [3:0] lanes_b;
        logic strict_leader;
        logic [1:0] eq_a_data;
        logic [1:0] eq_b_data;
        logic [1:0] eq_a_clk;
        logic [1:0] eq_b_clk;
        logic band_valid;
        logic dual_link;
        logic two_links;
    } dsrc_cfg_type;

endpackage : dsrc_pkg

// >>> rtl/dsrc_regs.sv
// Purpose: receiver configuration registers, decode and leader check
// Assumes: synchronous active-low reset, one-cycle strobes, link pins asynchronous
// Notes: decoded settings appear one cycle after the register changes
//
// Notes on behaviour
// - bit 7 picks odd/even split at 0, left/right halves at 1
// - mode bits 6-5: 00 dual receiver, 01 single, 10 two independent
// - bits 4-3 set channel A lanes: 00 four down to 11 one
// - bits 2-1 set channel B lanes with the same coding
// - bit 0 low accepts one-bit leader error, high rejects any error
// - equalization bits 7-6 set channel A data: 00 none, 01 1dB, 11 2dB
// - equalization bits 5-4 set channel B data with same coding
// - bits 3-2 channel A clock, bits 1-0 channel B clock equalization
// - clock band register in 5 MHz steps, valid codes 0x08 to 0x64
// - with both links on, modes 00/01 give dual link, 10 two links
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module dsrc_regs
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic links_both_on,
    input wire logic link_clk,
    input wire logic link_data,
    output logic [7:0] rd_data_ff,
    output dsrc_pkg::dsrc_cfg_type cfg_ff,
    output logic leader_ok_ff
);

    // ========================================
    // decode helpers
    function automatic logic [3:0] lane_mask(input logic [1:0] code);
        case (code)
            2'h0: lane_mask = 4'hf;
            2'h1: lane_mask = 4'h7;
            2'h2: lane_mask = 4'h3;
            default: lane_mask = 4'h1;
        endcase
    endfunction : lane_mask

    // equalization step: 0 none, 1 for 1 dB, 2 for 2 dB; reserved reads as none
    function automatic logic [1:0] eq_step(input logic [1:0] code);
        case (code)
            2'h1: eq_step = 2'h1;
            2'h3: eq_step = 2'h2;
            default: eq_step = 2'h0;
        endcase
    endfunction : eq_step

    function automatic logic [3:0] bit_errors(input logic [7:0] diff);
        logic [3:0] sum;
        sum = 4'h0;
        for (int i = 0; i < 8; i++)
        begin
            sum = sum + {3'h0, diff[i]};
        end
        bit_errors = sum;
    endfunction : bit_errors

    // ========================================
    // register storage
    logic [7:0] chan_cfg_ff;
    logic [7:0] lane_eq_ff;
    logic [7:0] clock_band_ff;
    logic [1:0] mode;
    logic [7:0] eq_fields;
    logic [7:0] eq_steps;

    // host writes, one strobe per cycle
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            chan_cfg_ff <= dsrc_pkg::RST_CHAN_CONFIG;
            lane_eq_ff <= dsrc_pkg::RST_LANE_EQ;
            clock_band_ff <= dsrc_pkg::RST_CLOCK_BAND;
        end
        else if (clk_en && wr_en)
        begin
            case (reg_addr)
                dsrc_pkg::OFS_CHAN_CONFIG: chan_cfg_ff <= wr_data;
                dsrc_pkg::OFS_LANE_EQ: lane_eq_ff <= wr_data;
                dsrc_pkg::OFS_CLOCK_BAND: clock_band_ff <= wr_data;
                default: ;
            endcase
        end
    end

    // read data stands for one enabled cycle after the strobe, held while clk_en is low; unmapped reads zero
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            rd_data_ff <= 8'h00;
        end
        else if (clk_en)
        begin
            if (rd_en)
            begin
                case (reg_addr)
                    dsrc_pkg::OFS_CHAN_CONFIG: rd_data_ff <= chan_cfg_ff;
                    dsrc_pkg::OFS_LANE_EQ: rd_data_ff <= lane_eq_ff;
                    dsrc_pkg::OFS_CLOCK_BAND: rd_data_ff <= clock_band_ff;
                    default: rd_data_ff <= 8'h00;
                endcase
            end
            else
            begin
                rd_data_ff <= 8'h00;
            end
        end
    end

    // ========================================
    // per-field equalization decode
    assign mode = chan_cfg_ff[dsrc_pkg::POS_MODE_LO +: 2];
    assign eq_fields = lane_eq_ff;

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_eq
            assign eq_steps[2*g +: 2] = eq_step(eq_fields[2*g +: 2]);
        end
    endgenerate

    // decoded settings, registered
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            cfg_ff <= '0;
            cfg_ff.single_rx <= 1'b1;
            cfg_ff.lanes_a <= 4'h1;
            cfg_ff.lanes_b <= 4'h1;
        end
        else if (clk_en)
        begin
            cfg_ff.left_right <= chan_cfg_ff[dsrc_pkg::POS_PIXEL_SPLIT];
            cfg_ff.dual_rx <= (mode == dsrc_pkg::MODE_DUAL_RX);
            cfg_ff.single_rx <= (mode == dsrc_pkg::MODE_SINGLE_RX);
            cfg_ff.two_rx <= (mode == dsrc_pkg::MODE_TWO_RX);
            cfg_ff.lanes_a <= lane_mask(chan_cfg_ff[dsrc_pkg::POS_LANES_A_LO +: 2]);
            cfg_ff.lanes_b <= lane_mask(chan_cfg_ff[dsrc_pkg::POS_LANES_B_LO +: 2]);
            cfg_ff.strict_leader <= chan_cfg_ff[dsrc_pkg::POS_STRICT];
            cfg_ff.eq_a_data <= eq_steps[dsrc_pkg::POS_EQ_A_DATA_LO +: 2];
            cfg_ff.eq_b_data <= eq_steps[dsrc_pkg::POS_EQ_B_DATA_LO +: 2];
            cfg_ff.eq_a_clk <= eq_steps[dsrc_pkg::POS_EQ_A_CLK_LO +: 2];
            cfg_ff.eq_b_clk <= eq_steps[dsrc_pkg::POS_EQ_B_CLK_LO +: 2];
            cfg_ff.band_valid <= (clock_band_ff >= dsrc_pkg::BAND_MIN)
                && (clock_band_ff <= dsrc_pkg::BAND_MAX);
            cfg_ff.dual_link <= links_both_on && (mode == dsrc_pkg::MODE_DUAL_RX
                || mode == dsrc_pkg::MODE_SINGLE_RX);
            cfg_ff.two_links <= links_both_on && (mode == dsrc_pkg::MODE_TWO_RX);
        end
    end

    // ========================================
    // link pin synchronisers and edge finder
    logic clk_s1_ff, clk_s2_ff, clk_s3_ff;
    logic dat_s1_ff, dat_s2_ff;
    logic [7:0] leader_sh_ff;
    logic [7:0] leader_next;
    logic [3:0] leader_errs;
    logic link_rise;

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            clk_s1_ff <= 1'b0;
            clk_s2_ff <= 1'b0;
            clk_s3_ff <= 1'b0;
            dat_s1_ff <= 1'b0;
            dat_s2_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            clk_s1_ff <= link_clk;
            clk_s2_ff <= clk_s1_ff;
            clk_s3_ff <= clk_s2_ff;
            dat_s1_ff <= link_data;
            dat_s2_ff <= dat_s1_ff;
        end
    end

    assign link_rise = clk_s2_ff && !clk_s3_ff;
    assign leader_next = {dat_s2_ff, leader_sh_ff[7:1]};
    assign leader_errs = bit_errors(leader_next ^ dsrc_pkg::LEADER_PATTERN);

    // shift serial bits in on each link rising edge, first bit ends in bit 0
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            leader_sh_ff <= 8'h00;
        end
        else if (clk_en && link_rise)
        begin
            leader_sh_ff <= leader_next;
        end
    end

    // leader match pulse, tolerance set by the strict bit
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            leader_ok_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            leader_ok_ff <= link_rise && ((leader_errs == 4'h0)
                || (leader_errs == 4'h1 && !chan_cfg_ff[dsrc_pkg::POS_STRICT]));
        end
    end

    // ========================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence s_cfg_write;
        clk_en && wr_en && reg_addr == dsrc_pkg::OFS_CHAN_CONFIG;
    endsequence
    sequence s_cfg_read;
        clk_en && rd_en && reg_addr == dsrc_pkg::OFS_CHAN_CONFIG;
    endsequence

    a_cfg_write_back: assert property (s_cfg_write ##1 1'b1 ##0 (clk_en && rd_en
        && reg_addr == dsrc_pkg::OFS_CHAN_CONFIG) |=> rd_data_ff == $past(wr_data, 2))
        else $error("config write not read back");
    a_eq_read_back: assert property (clk_en && rd_en && reg_addr == dsrc_pkg::OFS_LANE_EQ
        |=> rd_data_ff == $past(lane_eq_ff))
        else $error("equalization read mismatch");
    a_read_one_cycle: assert property (s_cfg_read ##1 (clk_en && !rd_en) |=> rd_data_ff == 8'h00)
        else $error("read data held too long");
    a_pixel_split: assert property (clk_en |=> cfg_ff.left_right == $past(chan_cfg_ff[7]))
        else $error("pixel split wrong");
    a_mode_decode: assert property (clk_en |=> cfg_ff.two_rx == ($past(chan_cfg_ff[6:5]) == 2'h2)
        && cfg_ff.dual_rx == ($past(chan_cfg_ff[6:5]) == 2'h0))
        else $error("receiver mode decode wrong");
    a_lanes_a: assert property (clk_en |=> cfg_ff.lanes_a == (4'hf >> $past(chan_cfg_ff[4:3])))
        else $error("channel A lane count wrong");
    a_lanes_b: assert property (clk_en |=> cfg_ff.lanes_b == (4'hf >> $past(chan_cfg_ff[2:1])))
        else $error("channel B lane count wrong");
    a_leader_strict: assert property (clk_en && chan_cfg_ff[0] && leader_errs != 4'h0
        |=> !leader_ok_ff)
        else $error("errored leader accepted in strict mode");
    a_leader_tolerant: assert property (clk_en && link_rise && !chan_cfg_ff[0] && leader_errs == 4'h1
        |=> leader_ok_ff)
        else $error("single error leader refused");
    a_eq_a_data: assert property (clk_en && lane_eq_ff[7:6] == 2'h3 |=> cfg_ff.eq_a_data == 2'h2)
        else $error("channel A data equalization wrong");
    a_eq_b_data: assert property (clk_en && lane_eq_ff[5:4] == 2'h1 |=> cfg_ff.eq_b_data == 2'h1)
        else $error("channel B data equalization wrong");
    a_eq_clocks: assert property (clk_en |=> cfg_ff.eq_a_clk == eq_step($past(lane_eq_ff[3:2]))
        && cfg_ff.eq_b_clk == eq_step($past(lane_eq_ff[1:0])))
        else $error("clock equalization wrong");
    a_band_valid: assert property (clk_en |=> cfg_ff.band_valid == ($past(clock_band_ff) >= 8'h08
        && $past(clock_band_ff) <= 8'h64))
        else $error("clock band validity wrong");
    a_link_config: assert property (clk_en && links_both_on && chan_cfg_ff[6:5] == 2'h2
        |=> cfg_ff.two_links && !cfg_ff.dual_link)
        else $error("two single links not selected");

endmodule : dsrc_regs

`default_nettype wire

// >>> tb/dsrc_host_model.sv
// Purpose: far-side host model driving the channel A link clock and lane 0
// Assumes: 80 ns half period, clock stands still between frames
// Notes: idle data line shows the inverse of its last bit
`timescale 1ns/1ps
`default_nettype none

module dsrc_host_model
(
    output var logic link_clk,
    output var logic link_data
);
    // ========================================
    // idle levels
    initial
    begin
        link_clk = 1'b0;
        link_data = 1'b0;
    end

    // ========================================
    // frame of 8 zeros then the test byte, first bit first, data moved with clock low
    task automatic send(input logic [7:0] b);
        logic [15:0] w;
        begin
            w = {b, 8'h00};
            for (int i = 0; i < 16; i++)
            begin
                link_data = w[i];
                #80 link_clk = 1'b1;
                #80 link_clk = 1'b0;
            end
            link_data = ~w[15]; // released line
        end
    endtask : send
endmodule : dsrc_host_model
`default_nettype wire

// >>> tb/dsrc_regs_tb_top.sv
// Purpose: self-checking bench for the receiver configuration bank
// Assumes: link traffic comes from the host model
// Notes: reserved mode and equalization codes are never written
`timescale 1ns/1ps
`default_nettype none

module dsrc_regs_tb_top;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic links_both_on = 1'b0;
    wire logic link_clk;
    wire logic link_data;
    logic [7:0] rd_data_ff;
    dsrc_pkg::dsrc_cfg_type cfg;
    logic leader_ok_ff;
    int mismatches = 0;
    int n_compared = 0;
    int n_pulse = 0;
    logic [7:0] v;
    logic [7:0] lb [5] = '{8'hb8, 8'hb9, 8'hf8, 8'hbb, 8'h38};

    // ========================================
    // clock, design and far side
    always #10 core_clk = ~core_clk;

    dsrc_regs u_dsrc_regs (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .links_both_on(links_both_on), .link_clk(link_clk),
        .link_data(link_data), .rd_data_ff(rd_data_ff), .cfg_ff(cfg), .leader_ok_ff(leader_ok_ff));

    dsrc_host_model u_dsrc_host_model (.link_clk(link_clk), .link_data(link_data));

    // counts leader pulses
    always @(posedge core_clk)
        if (leader_ok_ff === 1'b1)
            n_pulse++;

    // ========================================
    // helpers
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        begin
            n_compared++;
            if (g !== e)
            begin
                mismatches++;
                $display("[FAIL] %s expected %h seen %h", nm, e, g);
            end
        end
    endtask : chk

    // write, returns once the decoded settings have landed
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        begin
            @(posedge core_clk);
            reg_addr <= a;
            wr_data <= d;
            wr_en <= 1'b1;
            @(posedge core_clk);
            wr_en <= 1'b0;
            @(posedge core_clk);
            #1;
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        begin
            @(posedge core_clk);
            reg_addr <= a;
            rd_en <= 1'b1;
            @(posedge core_clk);
            rd_en <= 1'b0;
            #1 d = rd_data_ff;
        end
    endtask : rd

    // leader hits expected over the sliding windows of one frame
    function automatic int n_exp(input logic [7:0] b, input logic s);
        logic [15:0] w;
        int n;
        begin
            w = {b, 8'h00};
            n = 0;
            for (int j = 1; j <= 8; j++)
                if ($countones(w[j +: 8] ^ dsrc_pkg::LEADER_PATTERN) <= (s ? 0 : 1))
                    n++;
            return n;
        end
    endfunction : n_exp

    // ========================================
    // scenarios
    task automatic t_reset;
        begin
            rd(8'h10, v);
            chk("chan reset", 8'h3e, v);
            rd(8'h11, v);
            chk("eq reset", 8'h00, v);
            rd(8'h12, v);
            chk("band reset", 8'h00, v);
            chk("mode reset", 8'h10, 8'({cfg.left_right, cfg.dual_rx, cfg.single_rx, cfg.two_rx,
                cfg.strict_leader, cfg.dual_link, cfg.two_links}));
            chk("lanes reset", 8'h11, {cfg.lanes_a, cfg.lanes_b});
        end
    endtask : t_reset

    task automatic t_chan;
        logic [7:0] d;
        logic [1:0] m;
        logic [1:0] l;
        begin
            for (int i = 0; i < 12; i++)
            begin
                m = 2'(i / 4);
                l = 2'(i % 4);
                d = {m[0] ^ l[1], m, l, ~l, l[0]};
                links_both_on <= l[0];
                wr(8'h10, d);
                chk("chan decode", {1'b0, d[7], 3'b100 >> m, d[0], l[0] & ~m[1], l[0] & m[1]},
                    8'({cfg.left_right, cfg.dual_rx, cfg.single_rx, cfg.two_rx,
                    cfg.strict_leader, cfg.dual_link, cfg.two_links}));
                chk("lane masks", {4'hf >> l, 4'hf >> ~l}, {cfg.lanes_a, cfg.lanes_b});
                rd(8'h10, v);
                chk("chan readback", d, v);
            end
        end
    endtask : t_chan

    task automatic t_eq;
        logic [1:0] c [3] = '{2'h0, 2'h1, 2'h3};
        logic [1:0] e [3] = '{2'h0, 2'h1, 2'h2};
        begin
            for (int i = 0; i < 3; i++)
            begin
                wr(8'h11, {c[i], c[(i + 1) % 3], c[(i + 2) % 3], c[i]});
                chk("eq decode", {e[i], e[(i + 1) % 3], e[(i + 2) % 3], e[i]},
                    {cfg.eq_a_data, cfg.eq_b_data, cfg.eq_a_clk, cfg.eq_b_clk});
                rd(8'h11, v);
                chk("eq readback", {c[i], c[(i + 1) % 3], c[(i + 2) % 3], c[i]}, v);
            end
        end
    endtask : t_eq

    task automatic t_band;
        logic [7:0] b [4] = '{8'h07, 8'h08, 8'h64, 8'h65};
        begin
            for (int i = 0; i < 4; i++)
            begin
                wr(8'h12, b[i]);
                chk("band valid", {7'h00, i == 1 || i == 2}, {7'h00, cfg.band_valid});
                rd(8'h12, v);
                chk("band readback", b[i], v);
            end
        end
    endtask : t_band

    // write then read of one place with no gap, then idle read data
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
        begin
            @(posedge core_clk);
            reg_addr <= a;
            wr_data <= d;
            wr_en <= 1'b1;
            @(posedge core_clk);
            wr_en <= 1'b0;
            rd_en <= 1'b1;
            @(posedge core_clk);
            rd_en <= 1'b0;
            #1 chk("b2b read", d, rd_data_ff);
            @(posedge core_clk);
            #1 chk("read idle", 8'h00, rd_data_ff);
        end
    endtask : wr_rd

    // back to back on the equalization and channel registers, unmapped place, write while clock enable is low
    task automatic t_back_to_back;
        begin
            wr_rd(8'h11, 8'hd7);
            wr_rd(8'h10, 8'h5f);
            wr(8'h13, 8'h55);
            rd(8'h13, v);
            chk("unmapped", 8'h00, v);
            clk_en <= 1'b0;
            wr(8'h11, 8'h00);
            clk_en <= 1'b1;
            rd(8'h11, v);
            chk("eq kept", 8'hd7, v);
        end
    endtask : t_back_to_back

    task automatic t_leader(input logic s, input logic [7:0] b);
        int n0;
        begin
            wr(8'h10, {7'h1f, s});
            n0 = n_pulse;
            u_dsrc_host_model.send(b);
            repeat (8) @(posedge core_clk);
            #1 chk("leader hits", 8'(n_exp(b, s)), 8'(n_pulse - n0));
        end
    endtask : t_leader

    // ========================================
    // verdict, main sequence and watchdog
    task automatic end_of_test;
        begin
            $display("compared %0d mismatches %0d", n_compared, mismatches);
            if (mismatches == 0 && n_compared > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask : end_of_test

    initial
    begin
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        t_reset();
        t_chan();
        t_eq();
        t_band();
        t_back_to_back();
        foreach (lb[i])
            t_leader(1'b0, lb[i]);
        t_leader(1'b1, 8'hb8);
        t_leader(1'b1, 8'hb9);
        end_of_test();
    end

    initial
    begin
        #200000;
        mismatches++;
        end_of_test();
    end
endmodule : dsrc_regs_tb_top
`default_nettype wire
